// ---- verilog/mptb_time_base.sv ----
// Summary of operation
// RQ1 - 15-bit time base counter with input prescaler and match-output postscaler.
// RQ2 - Count register bit 15 is read-only direction: 0 up, 1 down.
// RQ3 - Enable bit starts and stops counting; clearing it keeps the count.
// RQ4 - Count compared to period; match resets or reverses on next tick.
// RQ5 - Zero period stops the counter and suppresses all events.
// RQ6 - Active zero period is not reloaded until the time base is disabled.
// RQ7 - Two-bit mode: free run, single shot, up/down, up/down double update.
// RQ8 - Free run counts up to period, then to zero, repeating.
// RQ9 - Free run raises a postscaled event on every period-match reset.
// RQ10 - Single shot counts up, resets on match and clears enable.
// RQ11 - Single shot gives one event at match, postscaler ignored.
// RQ12 - Up/down modes reverse at period; direction flag set going down.
// RQ13 - Up/down mode raises a postscaled event when count reaches zero.
// RQ14 - Double update raises events at zero and at period, unscaled.
// RQ15 - Event behaviour follows both mode and postscale fields.
// RQ16 - Software must never program a period of one.
// RQ17 - Prescaler 1, 4, 16 or 64; cleared on count/control write or reset.
// RQ18 - Postscaler 1 to 16; cleared on count/control write or reset.
// RQ19 - Period double buffered; loads at cycle restart or while disabled.
// RQ20 - Each postscaled event is a one-cycle interrupt pulse.
// RQ21 - Postscaler counts events, fires at selected ratio, restarts.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/10ps
`include "mptb_defines.svh"
module mptb_time_base
   import mptb_pkg::*;
#(
   parameter int ADDR_W = 8 // APB address width
) (
   input wire logic sys_clk_i,           // 250 MHz instruction-rate clock
   input wire logic rst_i,               // Synchronous reset, active high
   input wire logic psel_i,              // APB select
   input wire logic penable_i,           // APB enable
   input wire logic pwrite_i,            // APB write
   input wire logic [ADDR_W-1:0] paddr_i, // APB byte address
   input wire logic [31:0] pwdata_i,     // APB write data
   input wire logic [3:0] pstrb_i,       // APB byte strobes
   output logic [31:0] prdata_o,         // APB read data
   output logic pready_o,                // APB ready
   output logic pslverr_o,               // APB error, unmapped address
   output logic [14:0] count_o,          // Time base count to comparators
   output logic count_down_o,            // Direction, high while counting down
   output logic enable_o,                // Time base running
   output logic irq_pulse_o              // One-cycle interrupt event
);
   mptb_ctrl_s ctrl_reg;
   mptb_ctrl_s ctrl_next;
   logic [14:0] count_reg;
   logic [14:0] count_next;
   logic dir_reg;
   logic dir_next;
   logic [14:0] per_buf_reg;
   logic [14:0] per_buf_next;
   logic [14:0] per_act_reg;
   logic [14:0] per_act_next;
   logic irq_reg;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic err_reg;
   logic err_next;

   logic setup;
   logic wr_acc;
   logic wr_count;
   logic wr_ctrl;
   logic wr_per;
   logic presc_clear;
   logic tick;
   logic at_period;
   logic raw_event;
   logic post_bypass;
   logic post_event;
   logic load_period;
   logic hw_stop;
   logic [31:0] wmask;
   logic [31:0] ctrl_wword;

   function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
      addr_is = (a == ADDR_W'(ofs));
   endfunction : addr_is

   function automatic logic [31:0] ctrl_word(input mptb_ctrl_s c);
      logic [31:0] w;
      w = 32'h0000_0000;
      w[`MPTB_EN_BIT] = c.time_base_enable;
      w[`MPTB_OPS_HI:`MPTB_OPS_LO] = c.output_postscale_select;
      w[`MPTB_CKPS_HI:`MPTB_CKPS_LO] = c.input_prescale_select;
      w[`MPTB_MOD_HI:`MPTB_MOD_LO] = c.time_base_mode_select;
      ctrl_word = w;
   endfunction : ctrl_word

   // Zero-wait slave: read data is captured in the setup cycle
   assign setup = psel_i && !penable_i;
   assign wr_acc = psel_i && penable_i && pwrite_i;
   assign wr_count = wr_acc && addr_is(paddr_i, `MPTB_OFS_COUNT);
   assign wr_ctrl = wr_acc && addr_is(paddr_i, `MPTB_OFS_CONTROL);
   assign wr_per = wr_acc && addr_is(paddr_i, `MPTB_OFS_PERIOD);
   assign pready_o = 1'b1;
   assign pslverr_o = psel_i && penable_i && err_reg;
   assign prdata_o = rdata_reg;

   generate
      for (genvar b = 0; b < 4; b++) begin : g_mask
         assign wmask[b*8 +: 8] = {8{pstrb_i[b]}};
      end
   endgenerate

   assign presc_clear = wr_count || wr_ctrl; // see RQ17 see RQ18

   mptb_prescaler u_presc (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clear_i(presc_clear),
      .run_i(ctrl_reg.time_base_enable),
      .sel_i(ctrl_reg.input_prescale_select),
      .tick_o(tick)
   ); // see RQ1 see RQ17

   assign at_period = (count_reg == per_act_reg); // see RQ4

   always_comb begin
      raw_event = 1'b0;
      load_period = 1'b0;
      hw_stop = 1'b0;
      if (tick && (per_act_reg != `MPTB_ZERO15)) begin // see RQ5
         case (ctrl_reg.time_base_mode_select) // see RQ7 see RQ15
            MPTB_FREE_RUN: begin
               raw_event = at_period; // see RQ9
               load_period = at_period;
            end
            MPTB_SINGLE_SHOT: begin
               raw_event = at_period; // see RQ11
               load_period = at_period;
               hw_stop = at_period; // see RQ10
            end
            MPTB_UP_DOWN: begin
               raw_event = dir_reg && (count_reg <= `MPTB_ONE15); // see RQ13
               load_period = raw_event;
            end
            MPTB_UP_DOWN_DBL: begin
               load_period = dir_reg && (count_reg <= `MPTB_ONE15);
               raw_event = load_period || (!dir_reg && at_period); // see RQ14
            end
            default: begin
               raw_event = 1'b0;
            end
         endcase
      end
   end

   // Single shot and double update see every event
   assign post_bypass = ctrl_reg.time_base_mode_select == MPTB_SINGLE_SHOT ||
                        ctrl_reg.time_base_mode_select == MPTB_UP_DOWN_DBL; // see RQ11 see RQ14

   mptb_postscaler u_post (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .clear_i(presc_clear),
      .event_i(raw_event),
      .bypass_i(post_bypass),
      .sel_i(ctrl_reg.output_postscale_select),
      .event_o(post_event)
   ); // see RQ18 see RQ21

   always_comb begin
      ctrl_next = ctrl_reg;
      count_next = count_reg;
      dir_next = dir_reg;
      per_buf_next = per_buf_reg;
      per_act_next = per_act_reg;
      ctrl_wword = (ctrl_word(ctrl_reg) & ~wmask) | (pwdata_i & wmask);
      // A software write wins over the hardware stop in the same cycle
      if (hw_stop) begin
         ctrl_next.time_base_enable = 1'b0; // see RQ10
      end
      if (wr_ctrl) begin
         ctrl_next.time_base_enable = ctrl_wword[`MPTB_EN_BIT]; // see RQ3
         ctrl_next.output_postscale_select = ctrl_wword[`MPTB_OPS_HI:`MPTB_OPS_LO];
         ctrl_next.input_prescale_select = ctrl_wword[`MPTB_CKPS_HI:`MPTB_CKPS_LO];
         ctrl_next.time_base_mode_select = mptb_mode_e'(ctrl_wword[`MPTB_MOD_HI:`MPTB_MOD_LO]);
      end
      if (wr_per) begin
         per_buf_next = (per_buf_reg & ~wmask[14:0]) | (pwdata_i[14:0] & wmask[14:0]);
      end
      if (tick && (per_act_reg != `MPTB_ZERO15)) begin // see RQ5
         case (ctrl_reg.time_base_mode_select)
            MPTB_FREE_RUN, MPTB_SINGLE_SHOT: begin
               count_next = at_period ? `MPTB_ZERO15 : count_reg + `MPTB_ONE15; // see RQ8
               dir_next = 1'b0;
            end
            MPTB_UP_DOWN, MPTB_UP_DOWN_DBL: begin
               if (!dir_reg) begin
                  if (at_period) begin
                     dir_next = 1'b1; // see RQ12
                     count_next = count_reg - `MPTB_ONE15;
                  end else begin
                     count_next = count_reg + `MPTB_ONE15;
                  end
               end else if (count_reg <= `MPTB_ONE15) begin
                  dir_next = 1'b0; // see RQ13
                  count_next = `MPTB_ZERO15;
               end else begin
                  count_next = count_reg - `MPTB_ONE15;
               end
            end
            default: begin
               count_next = count_reg;
            end
         endcase
      end
      if (wr_count) begin
         count_next = (count_reg & ~wmask[14:0]) | (pwdata_i[14:0] & wmask[14:0]);
      end
      // Zero active period is frozen unless the time base is off
      if (!ctrl_reg.time_base_enable) begin
         per_act_next = per_buf_reg; // see RQ19 see RQ6
      end else if (load_period && (per_act_reg != `MPTB_ZERO15)) begin
         per_act_next = per_buf_reg; // see RQ19 see RQ6
      end
   end

   always_comb begin
      rdata_next = rdata_reg;
      err_next = err_reg;
      if (setup) begin
         err_next = 1'b1;
         rdata_next = 32'h0000_0000;
         if (addr_is(paddr_i, `MPTB_OFS_COUNT)) begin
            err_next = 1'b0;
            rdata_next = {16'h0000, dir_reg, count_reg}; // see RQ2
         end else if (addr_is(paddr_i, `MPTB_OFS_CONTROL)) begin
            err_next = 1'b0;
            rdata_next = ctrl_word(ctrl_reg);
         end else if (addr_is(paddr_i, `MPTB_OFS_PERIOD)) begin
            err_next = 1'b0;
            rdata_next = {17'h0_0000, per_buf_reg};
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         ctrl_reg <= '0;
         count_reg <= `MPTB_COUNT_RST;
         dir_reg <= 1'b0;
         per_buf_reg <= `MPTB_PERIOD_RST;
         per_act_reg <= `MPTB_PERIOD_RST;
         irq_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         count_reg <= count_next;
         dir_reg <= dir_next;
         per_buf_reg <= per_buf_next;
         per_act_reg <= per_act_next;
         irq_reg <= post_event; // see RQ20
         rdata_reg <= rdata_next;
         err_reg <= err_next;
      end
   end

   assign count_o = count_reg;
   assign count_down_o = dir_reg; // see RQ2
   assign enable_o = ctrl_reg.time_base_enable;
   assign irq_pulse_o = irq_reg;
endmodule : mptb_time_base

// ---- include/mptb_defines.svh ----
`ifndef MPTB_DEFINES_SVH
`define MPTB_DEFINES_SVH

// Register byte offsets
`define MPTB_OFS_COUNT 8'h00
`define MPTB_OFS_CONTROL 8'h04
`define MPTB_OFS_PERIOD 8'h08

// Control register fields
`define MPTB_EN_BIT 15
`define MPTB_OPS_HI 7
`define MPTB_OPS_LO 4
`define MPTB_CKPS_HI 3
`define MPTB_CKPS_LO 2
`define MPTB_MOD_HI 1
`define MPTB_MOD_LO 0

// Count register direction flag position
`define MPTB_DIR_BIT 15

// Reset values
`define MPTB_COUNT_RST 15'h0000
`define MPTB_PERIOD_RST 15'h0000
`define MPTB_ZERO15 15'h0000
`define MPTB_ONE15 15'h0001

// Prescaler terminal counts for 1:1, 1:4, 1:16, 1:64
`define MPTB_PRE_TC1 6'h00
`define MPTB_PRE_TC4 6'h03
`define MPTB_PRE_TC16 6'h0f
`define MPTB_PRE_TC64 6'h3f
`define MPTB_PRE_ONE 6'h01
`define MPTB_POST_ONE 4'h1

`endif

// ---- include/mptb_pkg.sv ----
package mptb_pkg;
   typedef enum logic [1:0] {
      MPTB_FREE_RUN = 2'h0,
      MPTB_SINGLE_SHOT = 2'h1,
      MPTB_UP_DOWN = 2'h2,
      MPTB_UP_DOWN_DBL = 2'h3
   } mptb_mode_e;

   typedef struct packed {
      logic time_base_enable;
      logic [3:0] output_postscale_select;
      logic [1:0] input_prescale_select;
      mptb_mode_e time_base_mode_select;
   } mptb_ctrl_s;
endpackage : mptb_pkg

// ---- verilog/mptb_prescaler.sv ----
`timescale 1ns/10ps
`include "mptb_defines.svh"
module mptb_prescaler
   import mptb_pkg::*;
(
   input wire logic sys_clk_i,   // Instruction-rate clock
   input wire logic rst_i,       // Synchronous reset
   input wire logic clear_i,     // Clear divider count
   input wire logic run_i,       // Count enable
   input wire logic [1:0] sel_i, // Ratio select
   output logic tick_o           // Counter input clock enable
);
   logic [5:0] cnt_reg;
   logic [5:0] cnt_next;
   logic [5:0] limit;

   function automatic logic [5:0] pre_limit(input logic [1:0] sel);
      case (sel)
         2'h0: pre_limit = `MPTB_PRE_TC1;
         2'h1: pre_limit = `MPTB_PRE_TC4;
         2'h2: pre_limit = `MPTB_PRE_TC16;
         default: pre_limit = `MPTB_PRE_TC64;
      endcase
   endfunction : pre_limit

   assign limit = pre_limit(sel_i);
   assign tick_o = run_i && !clear_i && (cnt_reg >= limit);

   always_comb begin
      cnt_next = cnt_reg;
      if (clear_i) begin
         cnt_next = 6'h00;
      end else if (run_i) begin
         cnt_next = tick_o ? 6'h00 : cnt_reg + `MPTB_PRE_ONE;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_reg <= 6'h00;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : mptb_prescaler

// ---- verilog/mptb_postscaler.sv ----
`timescale 1ns/10ps
`include "mptb_defines.svh"
module mptb_postscaler
   import mptb_pkg::*;
(
   input wire logic sys_clk_i,   // Instruction-rate clock
   input wire logic rst_i,       // Synchronous reset
   input wire logic clear_i,     // Clear postscale count
   input wire logic event_i,     // Qualifying time base event
   input wire logic bypass_i,    // Pass every event through
   input wire logic [3:0] sel_i, // Ratio minus one
   output logic event_o          // Postscaled event
);
   logic [3:0] cnt_reg;
   logic [3:0] cnt_next;

   assign event_o = event_i && (bypass_i || (cnt_reg >= sel_i));

   always_comb begin
      cnt_next = cnt_reg;
      if (clear_i || bypass_i) begin
         cnt_next = 4'h0;
      end else if (event_i) begin
         cnt_next = event_o ? 4'h0 : cnt_reg + `MPTB_POST_ONE;
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_next;
      end
   end
endmodule : mptb_postscaler

// ---- verif/mptb_time_base_assertions.sv ----
`timescale 1ns/10ps
module mptb_time_base_assertions #(
   parameter int ADDR_W = 8 // Address width
) (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic psel_i, // Select
   input wire logic penable_i, // Enable
   input wire logic pwrite_i, // Write
   input wire logic [ADDR_W-1:0] paddr_i, // Address
   input wire logic [31:0] pwdata_i, // Write data
   input wire logic [3:0] pstrb_i, // Strobes
   input wire logic [31:0] prdata_o, // Read data
   input wire logic pready_o, // Ready
   input wire logic pslverr_o, // Error
   input wire logic [14:0] count_o, // Count
   input wire logic count_down_o, // Direction
   input wire logic enable_o, // Running
   input wire logic irq_pulse_o // Event
);
   logic acc;
   logic wr_cnt;
   logic wr_ctl;
   assign acc = psel_i && penable_i;
   assign wr_cnt = acc && pwrite_i && paddr_i == 'h0;
   assign wr_ctl = acc && pwrite_i && paddr_i == 'h4;
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_shot_end;
      count_o == 15'h0 && irq_pulse_o ##1 !irq_pulse_o;
   endsequence
   a_ready_high: assert property (acc |-> pready_o)
      else $error("ready low in access");
   a_err_unmapped: assert property (acc |-> pslverr_o ==
      !(paddr_i == 'h0 || paddr_i == 'h4 || paddr_i == 'h8))
      else $error("error flag wrong");
   a_rd_upper: assert property (acc && !pwrite_i |-> prdata_o[31:16] == 16'h0)
      else $error("upper read bits set");
   a_count_hold: assert property (!enable_o && !wr_cnt |=> $stable(count_o))
      else $error("count moved while stopped");
   a_up_step: assert property (!count_down_o && $changed(count_o) && !$past(wr_cnt)
      |-> count_o == $past(count_o) + 15'h1 || count_o == 15'h0)
      else $error("bad upward step");
   a_down_step: assert property (count_down_o && $changed(count_o) && !$past(wr_cnt)
      |-> count_o == $past(count_o) - 15'h1)
      else $error("bad downward step");
   a_irq_single: assert property (irq_pulse_o |=> !irq_pulse_o)
      else $error("event pulse too long");
   a_irq_cause: assert property (irq_pulse_o |-> count_o == 15'h0 ||
      (count_down_o && !$past(count_down_o)))
      else $error("event without zero or match");
   a_shot_end: assert property ($fell(enable_o) && !$past(wr_ctl) |-> s_shot_end)
      else $error("hardware stop without reset and event");
endmodule : mptb_time_base_assertions
bind mptb_time_base mptb_time_base_assertions #(.ADDR_W(ADDR_W)) u_chk (
   .sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
   .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .count_o(count_o),
   .count_down_o(count_down_o), .enable_o(enable_o), .irq_pulse_o(irq_pulse_o));

// ---- verif/mptb_far_model.sv ----
`timescale 1ns/10ps
module mptb_far_model (
   input wire logic sys_clk_i, // Clock
   input wire logic rst_i, // Reset
   input wire logic irq_pulse_i, // Event pulse
   output int events_o, // Flag sets seen
   output int gap_o // Cycles between last two events
);
   int since;
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         events_o <= 0;
         gap_o <= 0;
         since <= 0;
      end else begin
         since <= irq_pulse_i ? 1 : since + 1;
         if (irq_pulse_i) begin
            events_o <= events_o + 1;
            gap_o <= since;
         end
      end
   end
endmodule : mptb_far_model

// ---- verif/mptb_time_base_tb_top.sv ----
`timescale 1ns/10ps
module mptb_time_base_tb_top;
   logic sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, err;
   logic pready_o, pslverr_o, count_down_o, enable_o, irq_pulse_o;
   logic [7:0] paddr_i;
   logic [3:0] pstrb_i;
   logic [31:0] pwdata_i, prdata_o, rd, d;
   logic [14:0] count_o, per, snap;
   int err_total, compares, seed, events, gap, base, ps;
   mptb_time_base u_dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .count_o(count_o), .count_down_o(count_down_o), .enable_o(enable_o),
      .irq_pulse_o(irq_pulse_o));
   mptb_far_model u_far (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .irq_pulse_i(irq_pulse_o),
      .events_o(events), .gap_o(gap));
   initial begin
      sys_clk_i = 1'b0;
      forever #2 sys_clk_i = ~sys_clk_i;
   end
   task automatic complete_run;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : complete_run
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      n = 0;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= v;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1);
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   task automatic wait_ev(input int n);
      int lim;
      lim = 0;
      base = events;
      while (events < base + n && lim < 30000) begin
         @(posedge sys_clk_i);
         lim++;
      end
   endtask : wait_ev
   // Double update: a match ends a p+1 tick gap, a zero a p-1 tick gap
   function automatic int exp_gap(input int m, input int k, input int s, input int p,
      input logic dn);
      case (m)
         0: return (p + 1) * k * (s + 1);
         2: return 2 * p * k * (s + 1);
         default: return dn ? (p + 1) * k : (p - 1) * k;
      endcase
   endfunction : exp_gap
   initial begin
      repeat (60000) @(posedge sys_clk_i);
      err_total++;
      complete_run();
   end
   initial begin
      seed = 23103;
      err_total = 0;
      compares = 0;
      rst_i = 1'b1;
      psel_i = 1'b0;
      penable_i = 1'b0;
      pwrite_i = 1'b0;
      paddr_i = 8'h00;
      pwdata_i = 32'h0;
      pstrb_i = 4'hf;
      repeat (8) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk("reset outs", 32'h0, {enable_o, count_down_o, count_o, irq_pulse_o});
      apb(1'b0, 8'h0c, 32'h0);
      chk("unmapped err", 32'h1, err);
      chk("unmapped data", 32'h0, rd);
      for (int i = 0; i < 3; i++) begin
         per = 15'($random(seed));
         d = $random(seed);
         apb(1'b1, 8'h08, {17'h0, per});
         apb(1'b0, 8'h08, 32'h0);
         chk("period buffer", {17'h0, per}, rd);
         apb(1'b1, 8'h00, d);
         apb(1'b0, 8'h00, 32'h0);
         chk("count reg", {17'h0, d[14:0]}, rd);
      end
      for (int m = 0; m < 4; m++) begin
         // Periods stay at two or more so no event floods the flag
         per = 15'(2 + $unsigned($random(seed)) % 8);
         ps = 1 + $unsigned($random(seed)) % 3;
         apb(1'b1, 8'h08, {17'h0, per});
         apb(1'b1, 8'h00, 32'h0);
         apb(1'b1, 8'h04, 32'h8000 | (ps << 4) | (m << 2) | m);
         if (m == 1) begin
            wait_ev(1);
            chk("shot end", 32'h0, {enable_o, count_o});
            base = events;
            repeat (200) @(posedge sys_clk_i);
            chk("shot events", base, events);
         end else begin
            wait_ev(3);
            chk("event gap", exp_gap(m, 1 << (2 * m), ps, per, count_down_o), gap);
         end
         apb(1'b1, 8'h04, 32'h0);
         snap = count_o;
         repeat (20) @(posedge sys_clk_i);
         chk("held count", snap, count_o);
      end
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h04, 32'h8000);
      base = events;
      snap = count_o;
      apb(1'b1, 8'h08, 32'h5);
      repeat (100) @(posedge sys_clk_i);
      chk("zero period count", snap, count_o);
      chk("zero period events", base, events);
      apb(1'b1, 8'h04, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      apb(1'b1, 8'h04, 32'h8000);
      repeat (50) @(posedge sys_clk_i);
      chk("restarted", 32'h1, events > base);
      rst_i <= 1'b1;
      repeat (2) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      chk("second reset", 32'h0, {enable_o, count_down_o, count_o});
      complete_run();
   end
endmodule : mptb_time_base_tb_top
